// ===== inc/spi_pin_pkg.sv
// Shared constants for the SPI pin link: register map, fields, timing
package spi_pin_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam int         ADDR_W   = 5;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_TXD  = 5'h04;
    localparam logic [4:0] REG_RXD  = 5'h08;
    localparam logic [4:0] REG_STAT = 5'h0C;
    localparam logic [4:0] REG_MASK = 5'h10;
    localparam logic [4:0] REG_FLAG = 5'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_EN                = 0;
    localparam int CTL_MASTER            = 1;
    localparam int CTL_CPOL              = 2;
    localparam int CTL_CPHA              = 3;
    localparam int CTL_OPEN_DRAIN_SELECT = 4;
    localparam int CTL_SLAVE_OUT_DISABLE = 5;
    localparam int CTL_RATE_LSB          = 6;
    localparam int ST_DONE               = 0;
    localparam int ST_MM_ERR             = 1;
    localparam int ST_BUSY               = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] FLAG_RST = 4'hF;
    localparam logic [1:0] MASK_RST = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS  = 5;
    localparam int         LINK_PERIOD_NS = 125;
    localparam int         PAR_HALF       =
        (LINK_PERIOD_NS / CLK_PERIOD_NS) / 2;
    localparam logic [6:0] PAR_DIV        = 7'(PAR_HALF - 1);
    localparam logic [6:0] HALF_BASE      = 7'h08;
    localparam logic [3:0] EDGE_LAST      = 4'hF;
    localparam logic [4:0] PAR_EDGE_TAIL  = 5'h10;

endpackage

// ===== inc/spi_pin_if.sv
// SPI pin link between the device end and the partner end
`timescale 1ns/1ps
interface spi_pin_if;

    // ------------------------------------------------------------
    // Per-party drivers, enables active low
    // ------------------------------------------------------------
    logic       dev_sclk_out;
    logic       dev_sclk_oe_n;
    logic       dev_mosi_out;
    logic       dev_mosi_oe_n;
    logic       dev_miso_out;
    logic       dev_miso_oe_n;
    logic [3:0] dev_flag;
    logic       par_sclk_out;
    logic       par_sclk_oe_n;
    logic       par_mosi_out;
    logic       par_mosi_oe_n;
    logic       par_miso_out;
    logic       par_miso_oe_n;
    logic       par_ss_n_out;

    // ------------------------------------------------------------
    // Resolved wires, pulled high when nobody drives
    // ------------------------------------------------------------
    logic       sclk;
    logic       mosi;
    logic       miso;
    logic       dev_ss_n;
    logic       par_ss_n;

    assign sclk = !dev_sclk_oe_n ? dev_sclk_out :
                  !par_sclk_oe_n ? par_sclk_out : 1'b1;
    assign mosi = !dev_mosi_oe_n ? dev_mosi_out :
                  !par_mosi_oe_n ? par_mosi_out : 1'b1;
    assign miso = !dev_miso_oe_n ? dev_miso_out :
                  !par_miso_oe_n ? par_miso_out : 1'b1;
    assign dev_ss_n = par_ss_n_out;
    assign par_ss_n = dev_flag[0];

    modport dev (
        output dev_sclk_out, dev_sclk_oe_n, dev_mosi_out, dev_mosi_oe_n,
        output dev_miso_out, dev_miso_oe_n, dev_flag,
        input  sclk, mosi, miso, dev_ss_n
    );

    modport par (
        output par_sclk_out, par_sclk_oe_n, par_mosi_out, par_mosi_oe_n,
        output par_miso_out, par_miso_oe_n, par_ss_n_out,
        input  sclk, mosi, miso, par_ss_n
    );

endinterface

// ===== logic/spi_pin_sync.sv
// Three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module spi_pin_sync #(
    parameter int           W   = 4,
    parameter logic [W-1:0] RST = '1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] agree_w;

    // Per-bit agreement of the two settled stages
    assign agree_w = ~(s2_r ^ s3_r);
    assign q_o     = q_r;

    // Shift chain and filtered output
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            q_r  <= RST;
        end
        else if (ce_i)
        begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= (agree_w & s3_r) | (~agree_w & q_r);
        end
    end

endmodule // spi_pin_sync

// ===== logic/spi_pin_device.sv
// Device end: SPI master/slave pin logic with Avalon-MM registers
`timescale 1ns/1ps
module spi_pin_device (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           ce_i,
    input  wire logic [spi_pin_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                           avs_read_i,
    input  wire logic                           avs_write_i,
    input  wire logic [3:0]                     avs_byteenable_i,
    input  wire logic [31:0]                    avs_writedata_i,
    output logic      [31:0]                    avs_readdata_o,
    output logic                                avs_waitrequest_o,
    output logic                                irq_o,
    spi_pin_if.dev                              link
);
    import spi_pin_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  serial_port_control_r;
    logic [3:0]  flag_r;
    logic [7:0]  txbuf_r;
    logic [7:0]  rx_r;
    logic [1:0]  stat_r;
    logic [1:0]  mask_r;
    logic        irq_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic [7:0]  sh_r;
    logic [7:0]  rsh_r;
    logic        out_r;
    logic [2:0]  smp_cnt_r;
    logic [3:0]  edge_cnt_r;
    logic [6:0]  div_r;
    logic        busy_r;
    logic        sclk_r;
    logic        sclk_q_r;
    logic        ss_q_r;
    logic        sclk_oe_n_r;
    logic        mosi_oe_n_r;
    logic        miso_oe_n_r;
    logic        sclk_s;
    logic        mosi_s;
    logic        miso_s;
    logic        ss_n_s;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    spi_pin_sync #(
        .W   (4),
        .RST (4'hF)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({link.sclk, link.mosi, link.miso, link.dev_ss_n}),
        .q_o   ({sclk_s, mosi_s, miso_s, ss_n_s})
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire req_w      = avs_read_i | avs_write_i;
    wire acc_w      = req_w & ~wait_r;
    wire wr_w       = acc_w & avs_write_i & avs_byteenable_i[0];
    wire hit_ctrl_w = avs_address_i == REG_CTRL;
    wire hit_txd_w  = avs_address_i == REG_TXD;
    wire hit_rxd_w  = avs_address_i == REG_RXD;
    wire hit_stat_w = avs_address_i == REG_STAT;
    wire hit_mask_w = avs_address_i == REG_MASK;
    wire hit_flag_w = avs_address_i == REG_FLAG;

    // Control fields
    wire       en_w     = serial_port_control_r[CTL_EN];
    wire       master_w = serial_port_control_r[CTL_MASTER];
    wire       cpol_w   = serial_port_control_r[CTL_CPOL];
    wire       cpha_w   = serial_port_control_r[CTL_CPHA];
    wire       od_w     = serial_port_control_r[CTL_OPEN_DRAIN_SELECT];
    wire       dis_w    = serial_port_control_r[CTL_SLAVE_OUT_DISABLE];
    wire [1:0] rate_w   = serial_port_control_r[CTL_RATE_LSB +: 2];

    // Read data selection, unmapped reads as zero
    logic [31:0] rd_mux_w;
    assign rd_mux_w =
        hit_ctrl_w ? {24'h000000, serial_port_control_r} :
        hit_txd_w  ? {24'h000000, txbuf_r} :
        hit_rxd_w  ? {24'h000000, rx_r} :
        hit_stat_w ? {29'h00000000, busy_r, stat_r} :
        hit_mask_w ? {30'h00000000, mask_r} :
        hit_flag_w ? {28'h0000000, flag_r} : 32'h00000000;

    // ------------------------------------------------------------
    // Shift engine decode
    // ------------------------------------------------------------
    // Half period of the master clock, scaled by rate
    wire [6:0] reload_w = (HALF_BASE << rate_w) - 7'h01;
    wire tick_w    = busy_r & (div_r == 7'h00);
    wire m_lead_w  = tick_w & ~edge_cnt_r[0];
    wire m_trail_w = tick_w & edge_cnt_r[0];

    // Slave edges only count while selected
    wire s_act_w   = en_w & ~master_w & ~ss_n_s;
    wire s_chg_w   = s_act_w & (sclk_s != sclk_q_r);
    wire s_lead_w  = s_chg_w & (sclk_q_r == cpol_w);
    wire s_trail_w = s_chg_w & (sclk_q_r != cpol_w);
    wire lead_w    = master_w ? m_lead_w : s_lead_w;
    wire trail_w   = master_w ? m_trail_w : s_trail_w;
    wire smp_w     = cpha_w ? trail_w : lead_w;
    wire chg_w     = cpha_w ? lead_w : trail_w;
    wire din_w     = master_w ? miso_s : mosi_s;

    // Word starts and events
    wire start_m_w = wr_w & hit_txd_w & en_w & master_w & ~busy_r;
    wire start_s_w = en_w & ~master_w & ss_q_r & ~ss_n_s;
    wire load_w    = start_m_w | start_s_w;
    wire [7:0] ld_w = start_m_w ? avs_writedata_i[7:0] : txbuf_r;
    wire mm_ev_w   = en_w & master_w & ~ss_n_s;
    wire done_ev_w = smp_w & (smp_cnt_r == 3'h7);
    wire stop_w    = mm_ev_w | ~en_w | ~master_w |
                     (tick_w & (edge_cnt_r == EDGE_LAST));
    wire out_nxt_w = (load_w & ~cpha_w) ? ld_w[7] :
                     chg_w ? sh_r[7] : out_r;
    wire slv_drv_w = s_act_w & ~dis_w;
    wire [1:0] w1c_w = (wr_w & hit_stat_w) ? avs_writedata_i[1:0] : 2'h0;
    wire [1:0] ev_w  = {mm_ev_w, done_ev_w};

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, then the access completes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h00000000;
        end
        else if (ce_i)
        begin
            wait_r <= ~(wait_r & req_w);
            if (wait_r & req_w)
                rdata_r <= rd_mux_w;
        end
    end

    // Software-written registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            serial_port_control_r <= CTRL_RST;
            flag_r                <= FLAG_RST;
            mask_r                <= MASK_RST;
            txbuf_r               <= 8'h00;
        end
        else if (ce_i & wr_w)
        begin
            if (hit_ctrl_w)
                serial_port_control_r <= avs_writedata_i[7:0];
            if (hit_flag_w)
                flag_r <= avs_writedata_i[3:0];
            if (hit_mask_w)
                mask_r <= avs_writedata_i[1:0];
            if (hit_txd_w)
                txbuf_r <= avs_writedata_i[7:0];
        end
    end

    // Sticky status, set beats clear, masked interrupt
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_r <= 2'h0;
            irq_r  <= 1'b0;
        end
        else if (ce_i)
        begin
            stat_r <= (stat_r & ~w1c_w) | ev_w;
            irq_r  <= |(stat_r & mask_r);
        end
    end

    // ------------------------------------------------------------
    // Master clock pacing
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_r     <= 1'b0;
            div_r      <= 7'h00;
            edge_cnt_r <= 4'h0;
        end
        else if (ce_i)
        begin
            if (start_m_w)
            begin
                busy_r     <= 1'b1;
                div_r      <= reload_w;
                edge_cnt_r <= 4'h0;
            end
            else if (busy_r & stop_w)
                busy_r <= 1'b0;
            else if (tick_w)
            begin
                div_r      <= reload_w;
                edge_cnt_r <= edge_cnt_r + 4'h1;
            end
            else if (busy_r)
                div_r <= div_r - 7'h01;
        end
    end

    // Serial clock level and edge history
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_r   <= 1'b0;
            sclk_q_r <= 1'b1;
            ss_q_r   <= 1'b1;
        end
        else if (ce_i)
        begin
            sclk_r   <= (busy_r & ~stop_w) | tick_w ?
                        sclk_r ^ tick_w : cpol_w;
            sclk_q_r <= sclk_s;
            ss_q_r   <= ss_n_s;
        end
    end

    // ------------------------------------------------------------
    // Data shifters, MSB first
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh_r      <= 8'h00;
            rsh_r     <= 8'h00;
            out_r     <= 1'b0;
            smp_cnt_r <= 3'h0;
            rx_r      <= 8'h00;
        end
        else if (ce_i)
        begin
            out_r <= out_nxt_w;
            if (smp_w)
            begin
                rsh_r     <= {rsh_r[6:0], din_w};
                smp_cnt_r <= smp_cnt_r + 3'h1;
            end
            if (done_ev_w)
                rx_r <= {rsh_r[6:0], din_w};
            if (load_w)
            begin
                sh_r      <= cpha_w ? ld_w : {ld_w[6:0], 1'b0};
                smp_cnt_r <= 3'h0;
            end
            else if (chg_w)
                sh_r <= {sh_r[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Pin direction and drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_oe_n_r <= 1'b1;
            mosi_oe_n_r <= 1'b1;
            miso_oe_n_r <= 1'b1;
        end
        else if (ce_i)
        begin
            sclk_oe_n_r <= ~(en_w & master_w);
            mosi_oe_n_r <= ~(en_w & master_w);
            miso_oe_n_r <= ~(slv_drv_w & (~od_w | ~out_nxt_w));
        end
    end

    // Outputs straight from registers
    assign avs_readdata_o     = rdata_r;
    assign avs_waitrequest_o  = wait_r;
    assign irq_o              = irq_r;
    assign link.dev_sclk_out  = sclk_r;
    assign link.dev_sclk_oe_n = sclk_oe_n_r;
    assign link.dev_mosi_out  = out_r;
    assign link.dev_mosi_oe_n = mosi_oe_n_r;
    assign link.dev_miso_out  = out_r;
    assign link.dev_miso_oe_n = miso_oe_n_r;
    assign link.dev_flag      = flag_r;

endmodule // spi_pin_device

// ===== logic/spi_pin_partner.sv
// Partner end: external SPI master or slave facing the device
`timescale 1ns/1ps
module spi_pin_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    spi_pin_if.par          link,
    input  wire logic       master_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic       start_i,
    input  wire logic [7:0] tx_data_i,
    output logic      [7:0] rx_data_o,
    output logic            done_o,
    output logic            busy_o
);
    import spi_pin_pkg::*;

    logic [7:0] sh_r;
    logic [7:0] rsh_r;
    logic [7:0] rx_r;
    logic       out_r;
    logic [2:0] smp_r;
    logic [4:0] edge_r;
    logic [6:0] div_r;
    logic       busy_r;
    logic       sclk_r;
    logic       ss_n_r;
    logic       done_r;
    logic       sclk_q_r;
    logic       ss_q_r;
    logic       mst_oe_n_r;
    logic       miso_oe_n_r;
    logic       sclk_s;
    logic       mosi_s;
    logic       miso_s;
    logic       ss_n_s;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    spi_pin_sync #(
        .W   (4),
        .RST (4'hF)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({link.sclk, link.mosi, link.miso, link.par_ss_n}),
        .q_o   ({sclk_s, mosi_s, miso_s, ss_n_s})
    );

    // Edge decode; last master tick only releases select
    wire tick_w  = busy_r & (div_r == 7'h00);
    wire tog_w   = tick_w & ~edge_r[4];
    wire s_act_w = ~master_i & ~ss_n_s;
    wire s_chg_w = s_act_w & (sclk_s != sclk_q_r);
    wire lead_w  = master_i ? tog_w & ~edge_r[0] :
                   s_chg_w & (sclk_q_r == cpol_i);
    wire trail_w = master_i ? tog_w & edge_r[0] :
                   s_chg_w & (sclk_q_r != cpol_i);
    wire smp_w   = cpha_i ? trail_w : lead_w;
    wire chg_w   = cpha_i ? lead_w : trail_w;
    wire din_w   = master_i ? miso_s : mosi_s;
    wire st_m_w  = start_i & master_i & ~busy_r;
    wire load_w  = st_m_w | (~master_i & ss_q_r & ~ss_n_s);
    wire out_nxt_w = (load_w & ~cpha_i) ? tx_data_i[7] :
                     chg_w ? sh_r[7] : out_r;

    // ------------------------------------------------------------
    // Master pacing and chip select
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_r <= 1'b0;
            ss_n_r <= 1'b1;
            div_r  <= 7'h00;
            edge_r <= 5'h00;
            sclk_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (st_m_w)
            begin
                busy_r <= 1'b1;
                ss_n_r <= 1'b0;
                div_r  <= PAR_DIV;
                edge_r <= 5'h00;
            end
            else if (tick_w & (edge_r == PAR_EDGE_TAIL))
            begin
                busy_r <= 1'b0;
                ss_n_r <= 1'b1;
            end
            else if (tick_w)
            begin
                div_r  <= PAR_DIV;
                edge_r <= edge_r + 5'h01;
            end
            else if (busy_r)
                div_r <= div_r - 7'h01;
            sclk_r <= busy_r ? sclk_r ^ tog_w : cpol_i;
        end
    end

    // ------------------------------------------------------------
    // Shifters, history and drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh_r        <= 8'h00;
            rsh_r       <= 8'h00;
            rx_r        <= 8'h00;
            out_r       <= 1'b0;
            smp_r       <= 3'h0;
            done_r      <= 1'b0;
            sclk_q_r    <= 1'b1;
            ss_q_r      <= 1'b1;
            mst_oe_n_r  <= 1'b1;
            miso_oe_n_r <= 1'b1;
        end
        else if (ce_i)
        begin
            out_r    <= out_nxt_w;
            sclk_q_r <= sclk_s;
            ss_q_r   <= ss_n_s;
            done_r   <= smp_w & (smp_r == 3'h7);
            if (smp_w)
            begin
                rsh_r <= {rsh_r[6:0], din_w};
                smp_r <= smp_r + 3'h1;
            end
            if (smp_w & (smp_r == 3'h7))
                rx_r <= {rsh_r[6:0], din_w};
            if (load_w)
            begin
                sh_r  <= cpha_i ? tx_data_i : {tx_data_i[6:0], 1'b0};
                smp_r <= 3'h0;
            end
            else if (chg_w)
                sh_r <= {sh_r[6:0], 1'b0};
            mst_oe_n_r  <= ~master_i;
            miso_oe_n_r <= ~s_act_w;
        end
    end

    assign rx_data_o          = rx_r;
    assign done_o             = done_r;
    assign busy_o             = busy_r;
    assign link.par_sclk_out  = sclk_r;
    assign link.par_sclk_oe_n = mst_oe_n_r;
    assign link.par_mosi_out  = out_r;
    assign link.par_mosi_oe_n = mst_oe_n_r;
    assign link.par_miso_out  = out_r;
    assign link.par_miso_oe_n = miso_oe_n_r;
    assign link.par_ss_n_out  = ss_n_r;

endmodule // spi_pin_partner

// ===== dv/spi_pin_checker.sv
// Assertions on the SPI pin link wires
`timescale 1ns/1ps
module spi_pin_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dev_sclk_out,
    input wire logic dev_sclk_oe_n,
    input wire logic dev_mosi_oe_n,
    input wire logic dev_miso_oe_n,
    input wire logic dev_ss_n,
    input wire logic par_sclk_out,
    input wire logic par_sclk_oe_n,
    input wire logic par_miso_oe_n,
    input wire logic par_ss_n
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Pin roles and select gating
    AST_DEV_ROLE: assert property (!dev_mosi_oe_n |-> dev_miso_oe_n)
        else $error("device drives both data lines");
    AST_DEV_SLV: assert property (!dev_sclk_oe_n |-> dev_miso_oe_n)
        else $error("master device drives master-in");
    AST_PAR_SLV: assert property (!par_sclk_oe_n |-> par_miso_oe_n)
        else $error("master partner drives master-in");
    AST_DEV_DESEL: assert property (dev_ss_n [*8] |-> dev_miso_oe_n)
        else $error("deselected device drives master-in");
    AST_PAR_DESEL: assert property (par_ss_n [*8] |-> par_miso_oe_n)
        else $error("deselected partner drives master-in");
    AST_RST_IDLE: assert property ($fell(rst_i) |-> dev_sclk_oe_n
        && dev_mosi_oe_n && dev_miso_oe_n) else $error("pins driven");
    // Clock pacing, at least 8 device or 9 partner cycles between toggles
    AST_DEV_PACE: assert property ($changed(dev_sclk_out)
        && !dev_sclk_oe_n |=> $stable(dev_sclk_out) [*7])
        else $error("device clock toggles too fast");
    AST_PAR_PACE: assert property ($changed(par_sclk_out)
        && !par_sclk_oe_n |=> $stable(par_sclk_out) [*8])
        else $error("partner clock toggles too fast");
endmodule // spi_pin_checker

// ===== dv/spi_pin_interface_tb_top.sv
// Self-checking bench for the SPI pin link
`timescale 1ns/1ps
module spi_pin_interface_tb_top;
    import spi_pin_pkg::*;
    logic        clk_i, rst_i, rd, wr, wq, irq, pm, pc, ph, st, pdn, pbz;
    logic [4:0]  adr;
    logic [31:0] wd, rdat, q;
    logic [7:0]  ptx, prx, d, p;
    logic        sq;
    int          err_count, n_checks, pd, tg, cy, r, t0, c0;
    spi_pin_if link ();
    spi_pin_device spi_pin_device_inst (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wd),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .irq_o(irq),
        .link(link));
    spi_pin_partner spi_pin_partner_inst (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .link(link), .master_i(pm), .cpol_i(pc), .cpha_i(ph),
        .start_i(st), .tx_data_i(ptx), .rx_data_o(prx), .done_o(pdn),
        .busy_o(pbz));
    spi_pin_checker spi_pin_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
        .dev_sclk_out(link.dev_sclk_out), .dev_ss_n(link.dev_ss_n),
        .dev_sclk_oe_n(link.dev_sclk_oe_n), .par_ss_n(link.par_ss_n),
        .dev_mosi_oe_n(link.dev_mosi_oe_n), .par_sclk_out(link.par_sclk_out),
        .dev_miso_oe_n(link.dev_miso_oe_n), .par_sclk_oe_n(link.par_sclk_oe_n),
        .par_miso_oe_n(link.par_miso_oe_n));
    // Clock, partner word counter and watchdog
    initial
    begin
        clk_i = 0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (pdn === 1'b1) pd <= pd + 1;
    // Link clock toggles, and cycles spent away from its idle level
    always @(posedge clk_i)
    begin
        sq <= link.sclk;
        if (sq !== link.sclk) tg <= tg + 1;
        if (link.sclk !== pc) cy <= cy + 1;
    end
    initial
    begin
        #100000;
        err_count++;
        report_and_stop;
    end
    // Bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input int v);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= v;
        @(posedge clk_i);
        while (wq !== 1'b0) @(posedge clk_i);
        q = rdat;
        rd <= 0;
        wr <= 0;
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] s, e);
        n_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected at %0t: %h not %h", $time, s, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Slave return data, all ones when the output is disabled
    function automatic logic [7:0] emiso(logic [7:0] x, int v);
        return (v == 2) ? 8'hFF : x;
    endfunction
    task automatic pstart;
        st <= 1;
        @(posedge clk_i);
        st <= 0;
    endtask
    // Main sequence
    initial
    begin
        {rd, wr, st, pm, pc, ph, adr, wd, ptx} = 0;
        {pd, err_count, n_checks} = 0;
        rst_i = 1;
        void'($urandom(32'hF6F5));
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        bus(0, REG_FLAG, 0);
        chk(q, 32'hF);
        bus(0, 5'h1C, 0);
        chk(q, 0);
        bus(1, REG_MASK, 1);
        for (int m = 0; m < 4; m++)
        begin
            d = 8'($urandom);
            p = 8'($urandom);
            ptx <= p;
            pc <= m[0];
            ph <= m[1];
            // Rate 0 is too fast for a slave behind pin synchronisers
            r = 1 + m % 3;
            bus(1, REG_CTRL, 3 + 4 * m[0] + 8 * m[1] + 64 * r);
            bus(1, REG_FLAG, 'hE);
            t0 = tg;
            c0 = cy;
            bus(1, REG_TXD, d);
            do bus(0, REG_STAT, 0); while (q[ST_BUSY] !== 1'b0);
            chk(q[1:0], 2'b01);
            chk(link.sclk, m[0]);
            chk(irq, 1);
            chk(tg - t0, 16);
            chk(cy - c0, (HALF_BASE << r) * 8);
            wait (pd == m + 1);
            chk(prx, d);
            bus(0, REG_RXD, 0);
            chk(q[7:0], p);
            bus(1, REG_STAT, 1);
            bus(1, REG_FLAG, 'hF);
        end
        {pm, pc, ph} <= 3'b100;
        for (int v = 0; v < 3; v++)
        begin
            d = 8'($urandom);
            p = 8'($urandom);
            ptx <= p;
            bus(1, REG_CTRL, 1 + 16 * v);
            bus(1, REG_TXD, d);
            pstart;
            wait (pd == 5 + v);
            wait (pbz === 1'b0);
            chk(prx, emiso(d, v));
            do bus(0, REG_STAT, 0); while (q[ST_DONE] !== 1'b1);
            bus(1, REG_STAT, 1);
            bus(0, REG_RXD, 0);
            chk(q[7:0], p);
        end
        bus(1, REG_CTRL, 3);
        pstart;
        wait (pd == 8);
        bus(0, REG_STAT, 0);
        chk(q[ST_MM_ERR], 1);
        chk(irq, 0);
        report_and_stop;
    end
endmodule // spi_pin_interface_tb_top
